/* File: hdl/vrefc_ctrl.sv */
// reference control register and the analog control lines it drives
//
// What this block does
// - source select bit: 0 routes reference pin, 1 routes supply to converter
// - bias enable forced high when converter, sensor, oscillators or current DAC enabled
// - writing bias bit 1 turns bias on; 0 turns off unless forced
// - buffer enable bit 1 drives internal reference onto pin; 0 disables buffer
// - sensor enable bit 1 turns sensor on; 0 leaves output high impedance
// - upper four register bits read zero, writes ignored
`timescale 1ns/1ps
module vrefc_ctrl
   import vrefc_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_we_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_re_i,
   input wire logic [VREFC_DEP_COUNT-1:0] dep_enable_i,
   output logic [7:0] sfr_rdata_o,
   output logic ref_source_select_o,
   output logic temp_sensor_enable_o,
   output logic bias_gen_enable_o,
   output logic ref_buffer_enable_o
);
   logic [VREFC_FIELD_BITS-1:0] field_r;
   logic hit;
   logic bias_nxt;

   // register image: stored field, unused upper bits read as zero
   function automatic logic [7:0] read_image(input logic [VREFC_FIELD_BITS-1:0] field);
      return {{(8 - VREFC_FIELD_BITS){1'h0}}, field};
   endfunction

   assign hit = (sfr_addr_i == VREFC_REFERENCE_CONTROL_ADDR);

   // only the low field is stored; upper bits have no storage
   vrefc_field_reg #(
      .WIDTH(VREFC_FIELD_BITS),
      .RESET_VALUE(VREFC_REFERENCE_CONTROL_RESET[VREFC_FIELD_BITS-1:0])
   ) u_field (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .we_i(sfr_we_i && hit),
      .wdata_i(sfr_wdata_i[VREFC_FIELD_BITS-1:0] & VREFC_FIELD_MASK),
      .q_o(field_r)
   );

   // read data registered; stored bias bit, upper nibble zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_re_i && hit) begin
         sfr_rdata_o <= read_image(field_r);
      end else begin
         sfr_rdata_o <= 8'h00;
      end
   end

   // forced by any dependent peripheral; stored bit stays as written
   assign bias_nxt = field_r[VREFC_BIAS_GEN_ENABLE_BIT] | (|dep_enable_i);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_source_select_o <= 1'h0;
      end else begin
         ref_source_select_o <= field_r[VREFC_REF_SOURCE_SELECT_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         temp_sensor_enable_o <= 1'h0;
      end else begin
         temp_sensor_enable_o <= field_r[VREFC_TEMP_SENSOR_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bias_gen_enable_o <= 1'h0;
      end else begin
         bias_gen_enable_o <= bias_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_buffer_enable_o <= 1'h0;
      end else begin
         ref_buffer_enable_o <= field_r[VREFC_REF_BUFFER_ENABLE_BIT];
      end
   end

   property p_bias_forced;
      @(posedge clk_i) disable iff (!resetn_i)
      (|dep_enable_i) |=> bias_gen_enable_o;
   endproperty
   a_bias_forced: assert property (p_bias_forced) else $error("bias not forced on");

   property p_bias_write;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_we_i && hit) ##1 1'h1 |=> bias_gen_enable_o ==
         ($past(sfr_wdata_i[VREFC_BIAS_GEN_ENABLE_BIT], 2) | $past(|dep_enable_i));
   endproperty
   a_bias_write: assert property (p_bias_write) else $error("bias does not follow write");

   property p_src_write;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_we_i && hit) |=> ##1 ref_source_select_o ==
         $past(sfr_wdata_i[VREFC_REF_SOURCE_SELECT_BIT], 2);
   endproperty
   a_src_write: assert property (p_src_write) else $error("source select wrong");

   property p_buf_write;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_we_i && hit) |=> ##1 ref_buffer_enable_o ==
         $past(sfr_wdata_i[VREFC_REF_BUFFER_ENABLE_BIT], 2);
   endproperty
   a_buf_write: assert property (p_buf_write) else $error("buffer enable wrong");

   property p_temp_write;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_we_i && hit) |=> ##1 temp_sensor_enable_o ==
         $past(sfr_wdata_i[VREFC_TEMP_SENSOR_ENABLE_BIT], 2);
   endproperty
   a_temp_write: assert property (p_temp_write) else $error("sensor enable wrong");

   property p_upper_zero;
      @(posedge clk_i) disable iff (!resetn_i)
      sfr_rdata_o[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

   property p_read_stored;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_re_i && hit && !sfr_we_i) |=>
         sfr_rdata_o[VREFC_BIAS_GEN_ENABLE_BIT] == $past(field_r[VREFC_BIAS_GEN_ENABLE_BIT]);
   endproperty
   a_read_stored: assert property (p_read_stored) else $error("bias read not stored value");

   property p_read_idle;
      @(posedge clk_i) disable iff (!resetn_i)
      !(sfr_re_i && hit) |=> sfr_rdata_o == 8'h00;
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("read data not zero when idle");

   property p_field_hold;
      @(posedge clk_i) disable iff (!resetn_i)
      !(sfr_we_i && hit) |=> $stable(field_r);
   endproperty
   a_field_hold: assert property (p_field_hold) else $error("field changed without write");

   property p_addr_refused;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_we_i && !hit) |=> $stable(field_r);
   endproperty
   a_addr_refused: assert property (p_addr_refused) else $error("other address was stored");

   property p_field_store;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_we_i && hit) |=> field_r == $past(sfr_wdata_i[VREFC_FIELD_BITS-1:0]);
   endproperty
   a_field_store: assert property (p_field_store) else $error("low field not stored");

   property p_read_image;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_re_i && hit) |=> sfr_rdata_o == read_image($past(field_r));
   endproperty
   a_read_image: assert property (p_read_image) else $error("read image wrong");

   property p_bias_read_unforced;
      @(posedge clk_i) disable iff (!resetn_i)
      (sfr_re_i && hit && !field_r[VREFC_BIAS_GEN_ENABLE_BIT]) |=>
         !sfr_rdata_o[VREFC_BIAS_GEN_ENABLE_BIT];
   endproperty
   a_bias_read_unforced: assert property (p_bias_read_unforced) else $error("forced bias read");

   property p_bias_manual;
      @(posedge clk_i) disable iff (!resetn_i)
      field_r[VREFC_BIAS_GEN_ENABLE_BIT] |=> bias_gen_enable_o;
   endproperty
   a_bias_manual: assert property (p_bias_manual) else $error("bias not on when written");

   property p_bias_off;
      @(posedge clk_i) disable iff (!resetn_i)
      !field_r[VREFC_BIAS_GEN_ENABLE_BIT] && !(|dep_enable_i) |=> !bias_gen_enable_o;
   endproperty
   a_bias_off: assert property (p_bias_off) else $error("bias on without cause");

   property p_bias_track;
      @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |->
         bias_gen_enable_o == ($past(field_r[VREFC_BIAS_GEN_ENABLE_BIT]) | $past(|dep_enable_i));
   endproperty
   a_bias_track: assert property (p_bias_track) else $error("bias not stored or forced");

   property p_src_follow;
      @(posedge clk_i) disable iff (!resetn_i)
      ref_source_select_o == $past(field_r[VREFC_REF_SOURCE_SELECT_BIT]);
   endproperty
   a_src_follow: assert property (p_src_follow) else $error("source select lags field");

   property p_temp_follow;
      @(posedge clk_i) disable iff (!resetn_i)
      temp_sensor_enable_o == $past(field_r[VREFC_TEMP_SENSOR_ENABLE_BIT]);
   endproperty
   a_temp_follow: assert property (p_temp_follow) else $error("sensor enable lags field");

   property p_buf_follow;
      @(posedge clk_i) disable iff (!resetn_i)
      ref_buffer_enable_o == $past(field_r[VREFC_REF_BUFFER_ENABLE_BIT]);
   endproperty
   a_buf_follow: assert property (p_buf_follow) else $error("buffer enable lags field");

   property p_ctl_stable;
      @(posedge clk_i) disable iff (!resetn_i)
      $stable(field_r) |=>
         $stable({ref_source_select_o, temp_sensor_enable_o, ref_buffer_enable_o});
   endproperty
   a_ctl_stable: assert property (p_ctl_stable) else $error("control line moved");
endmodule

/* File: hdl/vrefc_field_reg.sv */
// small storage register for the writable low field
`timescale 1ns/1ps
module vrefc_field_reg
   import vrefc_pkg::*;
#(
   parameter int WIDTH = VREFC_FIELD_BITS,
   parameter logic [WIDTH-1:0] RESET_VALUE = VREFC_REFERENCE_CONTROL_RESET[WIDTH-1:0]
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic we_i,
   input wire logic [WIDTH-1:0] wdata_i,
   output logic [WIDTH-1:0] q_o
);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_o <= RESET_VALUE;
      end else if (we_i) begin
         q_o <= wdata_i;
      end
   end
endmodule

/* File: hdl/vrefc_pkg.sv */
// package: register address, field positions and reset value of the reference control register
package vrefc_pkg;
   localparam logic [7:0] VREFC_REFERENCE_CONTROL_ADDR = 8'hD1;
   localparam logic [7:0] VREFC_REFERENCE_CONTROL_RESET = 8'h00;
   localparam int VREFC_REF_BUFFER_ENABLE_BIT = 0;
   localparam int VREFC_BIAS_GEN_ENABLE_BIT = 1;
   localparam int VREFC_TEMP_SENSOR_ENABLE_BIT = 2;
   localparam int VREFC_REF_SOURCE_SELECT_BIT = 3;
   localparam int VREFC_FIELD_BITS = 4;
   localparam logic [3:0] VREFC_FIELD_MASK = 4'hF;
   // dependent peripherals that force the bias generator on
   localparam int VREFC_DEP_ADC = 0;
   localparam int VREFC_DEP_TEMP = 1;
   localparam int VREFC_DEP_OSC = 2;
   localparam int VREFC_DEP_IDAC = 3;
   localparam int VREFC_DEP_COUNT = 4;
endpackage

/* File: verification/vrefc_ctrl_test.sv */
// self-checking testbench for the reference control register block
`timescale 1ns/1ps
module vrefc_ctrl_test
   import vrefc_pkg::*;
;
   logic clk_i = 1'h0;
   logic resetn_i = 1'h0;
   logic sfr_we_i = 1'h0;
   logic sfr_re_i = 1'h0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] sfr_rdata_o;
   logic [VREFC_DEP_COUNT-1:0] dep_enable_i = '0;
   logic ref_source_select_o, temp_sensor_enable_o, bias_gen_enable_o, ref_buffer_enable_o;
   logic [3:0] ctl;
   int error_cnt = 0;
   int n_tests = 0;
   // stand-ins for the port set-up registers outside this block; values arbitrary
   localparam logic [7:0] PORT_INPUT_MODE_ADDR = 8'hF1;
   localparam logic [7:0] CROSSBAR_SKIP_ADDR = 8'hD4;
   // control lines packed in register bit order
   assign ctl = {ref_source_select_o, temp_sensor_enable_o, bias_gen_enable_o, ref_buffer_enable_o};
   vrefc_ctrl i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
      .sfr_we_i(sfr_we_i), .sfr_wdata_i(sfr_wdata_i), .sfr_re_i(sfr_re_i),
      .dep_enable_i(dep_enable_i), .sfr_rdata_o(sfr_rdata_o),
      .ref_source_select_o(ref_source_select_o), .temp_sensor_enable_o(temp_sensor_enable_o),
      .bias_gen_enable_o(bias_gen_enable_o), .ref_buffer_enable_o(ref_buffer_enable_o));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // write, then wait until the output flop has taken it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_we_i = 1'h1;
      @(negedge clk_i);
      sfr_we_i = 1'h0;
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] exp);
      @(negedge clk_i);
      sfr_addr_i = VREFC_REFERENCE_CONTROL_ADDR;
      sfr_re_i = 1'h1;
      @(negedge clk_i);
      sfr_re_i = 1'h0;
      chk("rdata", sfr_rdata_o, exp);
      @(negedge clk_i);
      chk("rdata idle", sfr_rdata_o, 8'h00);
   endtask
   task automatic end_of_test();
      $display("Checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk_i);
      resetn_i = 1'h1;
      chk("ctl reset", {4'h0, ctl}, 8'h00);
      rd(VREFC_REFERENCE_CONTROL_RESET);
      // shared pin set up for a reference, then internal, then supply reference
      wr(PORT_INPUT_MODE_ADDR, 8'hFE);
      wr(CROSSBAR_SKIP_ADDR, 8'h01);
      chk("ctl foreign", {4'h0, ctl}, 8'h00);
      wr(VREFC_REFERENCE_CONTROL_ADDR, 8'h01);
      chk("ctl internal", {4'h0, ctl}, 8'h01);
      wr(VREFC_REFERENCE_CONTROL_ADDR, 8'h08);
      chk("ctl supply", {4'h0, ctl}, 8'h08);
      rd(8'h08);
      for (int i = 0; i < 4; i++) begin
         wr(VREFC_REFERENCE_CONTROL_ADDR, 8'hF0 | (8'h01 << i));
         chk("ctl bit", {4'h0, ctl}, 8'h01 << i);
         rd(8'h01 << i);
      end
      wr(VREFC_REFERENCE_CONTROL_ADDR, 8'hFF);
      chk("ctl all", {4'h0, ctl}, 8'h0F);
      wr(8'hD0, 8'h00);
      rd(8'h0F);
      wr(VREFC_REFERENCE_CONTROL_ADDR, 8'h00);
      chk("ctl clear", {4'h0, ctl}, 8'h00);
      for (int i = 0; i < VREFC_DEP_COUNT; i++) begin
         dep_enable_i = VREFC_DEP_COUNT'(1 << i);
         @(negedge clk_i);
         chk("bias forced", {4'h0, ctl}, 8'h02);
         rd(8'h00);
         dep_enable_i = '0;
         @(negedge clk_i);
         chk("bias released", {7'h00, bias_gen_enable_o}, 8'h00);
      end
      // reset in mid-run clears the stored field and all lines
      wr(VREFC_REFERENCE_CONTROL_ADDR, 8'h06);
      resetn_i = 1'h0;
      repeat (2) @(negedge clk_i);
      chk("ctl in reset", {4'h0, ctl}, 8'h00);
      chk("rdata in reset", sfr_rdata_o, 8'h00);
      resetn_i = 1'h1;
      @(negedge clk_i);
      chk("ctl after reset", {4'h0, ctl}, 8'h00);
      rd(VREFC_REFERENCE_CONTROL_RESET);
      end_of_test();
   end
   initial begin
      #(500 * 8);
      error_cnt++;
      end_of_test();
   end
endmodule
